// ===== pmirq_regs.sv
`timescale 1ns/10ps
// Behaviour
// - Mode 000: 10M half, no autoneg
// - Mode 001: 10M full, no autoneg
// - Mode 010: 100M half, carrier on tx
// - Mode 011: 100M full, carrier rx only
// - Mode 100: autoneg, advertise 100M half
// - Mode 101: repeater, same presets, rx carrier
// - Mode 111: autoneg, advertise everything
// - PLL force bit pins receive PLL
// - Bit 4 reports 10M polarity reversal
// - Low nibble reads fixed, ignores writes
// - Latch energy, autoneg, fault, link down
// - Latch ack, parallel fault, page received
// - Mask low byte enables sources
// - Autodone bit shows finished autoneg in modes 100, 101 and 111 only
// - Bits 4-2 report resolved speed/duplex
// - Mode bits 7:5, address bits 4:0
module pmirq_regs
  import pmirq_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Management interface pins
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  // Configuration straps
  input  wire logic [2:0] strap_mode,
  input  wire logic [4:0] strap_phy_mgmt_address,
  // PHY core status
  input  pmirq_evt_type   evt,
  // Outputs to the PHY core
  output logic            phy_irq,
  output logic            rx_pll_force_reference,
  output pmirq_preset_type preset
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] pin_s;
  logic [7:0] strap_s;
  logic       mdc_d_reg;
  logic       mdc_rise;
  logic       bit_in;

  pmirq_sync #(.WIDTH(2)) u_pin_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({mdc, mdio_in}),
    .dout (pin_s)
  );

  pmirq_sync #(.WIDTH(8)) u_strap_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({strap_mode, strap_phy_mgmt_address}),
    .dout (strap_s)
  );

  // Edge detect reads only the second stage
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) mdc_d_reg <= 1'b0;
    else     mdc_d_reg <= pin_s[1];
  end
  assign mdc_rise = pin_s[1] & ~mdc_d_reg;
  assign bit_in   = pin_s[0];

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [2:0]    mode_reg,  mode_next;
  logic [4:0]    phy_mgmt_address_reg, phy_mgmt_address_next;
  logic          strap_done_reg;
  logic [1:0]    strap_age_reg;
  logic          pll_reg,   pll_next;
  logic [7:0]    mask_reg,  mask_next;
  logic [7:0]    flags_reg, flags_next;
  logic [6:0]    ls_rsvd_reg, ls_rsvd_next;
  pmirq_evt_type evt_d_reg;
  logic [7:0]    flag_set;
  logic          flag_clr;
  logic          wr_stb;
  logic [4:0]    wr_addr;
  logic [15:0]   wr_data;
  pmirq_preset_type dec_preset;

  pmirq_mode_dec u_mode_dec (
    .mode   (mode_reg),
    .preset (dec_preset)
  );

  // Event edges; bit 0 is never a source
  always_comb begin
    flag_set    = '0;
    flag_set[7] = evt.energy_present & ~evt_d_reg.energy_present;
    flag_set[6] = evt.autoneg_done & ~evt_d_reg.autoneg_done;
    flag_set[5] = evt.remote_fault & ~evt_d_reg.remote_fault;
    flag_set[4] = ~evt.link_up & evt_d_reg.link_up;
    flag_set[3] = evt.partner_ack & ~evt_d_reg.partner_ack;
    flag_set[2] = evt.parallel_detect_fault
                  & ~evt_d_reg.parallel_detect_fault;
    flag_set[1] = evt.page_received & ~evt_d_reg.page_received;
  end

  // Next register values; a new event wins over a read clear
  always_comb begin
    mode_next    = mode_reg;
    phy_mgmt_address_next   = phy_mgmt_address_reg;
    pll_next     = pll_reg;
    mask_next    = mask_reg;
    ls_rsvd_next = ls_rsvd_reg;
    flags_next   = (flags_reg & ~{8{flag_clr}}) | flag_set;
    if (!strap_done_reg && strap_age_reg[1]) begin   // Sync stages full
      mode_next  = strap_s[7:5];
      phy_mgmt_address_next = strap_s[4:0];
    end else if (wr_stb) begin
      case (wr_addr)
        REG_SPECIAL_MODES: begin
          mode_next  = wr_data[MODE_LSB +: 3];
          phy_mgmt_address_next = wr_data[4:0];
        end
        REG_CTRL_STATUS: pll_next  = wr_data[CS_PLL_BIT];
        REG_IRQ_MASK:    mask_next = wr_data[7:0];
        REG_LINK_STATUS: ls_rsvd_next = wr_data[LS_RSVD_LSB +: 7];
        default: ;
      endcase
    end
  end

  // Straps are caught on the third edge after reset release, once the
  // cleared synchroniser stages have filled with the real pin levels
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_reg       <= MODE_RESET;
      phy_mgmt_address_reg      <= PHY_MGMT_ADDRESS_RESET;
      strap_done_reg <= 1'b0;
      strap_age_reg  <= '0;
      pll_reg        <= 1'b0;
      mask_reg       <= MASK_RESET;
      flags_reg      <= '0;
      ls_rsvd_reg    <= LS_RSVD_RESET;
      evt_d_reg      <= '0;
    end else begin
      mode_reg       <= mode_next;
      phy_mgmt_address_reg      <= phy_mgmt_address_next;
      strap_done_reg <= strap_age_reg[1];
      strap_age_reg  <= {strap_age_reg[0], 1'b1};
      pll_reg        <= pll_next;
      mask_reg       <= mask_next;
      flags_reg      <= flags_next;
      ls_rsvd_reg    <= ls_rsvd_next;
      evt_d_reg      <= evt;
    end
  end

  // ****************************************************************
  // Read view
  // ****************************************************************
  logic [4:0]  rd_addr;
  logic [15:0] rd_word;

  // Unmapped indices read as zero
  always_comb begin
    rd_word = '0;
    case (rd_addr)
      REG_SPECIAL_MODES: rd_word[7:0] = {mode_reg, phy_mgmt_address_reg};
      REG_CTRL_STATUS: begin
        rd_word[CS_PLL_BIT] = pll_reg;
        rd_word[CS_POL_BIT] = evt.ten_meg_polarity_reversed;
        rd_word[3:0]        = CS_FIXED;
      end
      REG_IRQ_FLAGS: rd_word[7:1] = flags_reg[7:1];
      REG_IRQ_MASK:  rd_word[7:0] = mask_reg;
      REG_LINK_STATUS: begin
        // Done only counts while autonegotiation is in use
        rd_word[LS_DONE_BIT] = evt.autoneg_done
                               & dec_preset.ctrl_bits[2];
        rd_word[LS_RSVD_LSB +: 7] = ls_rsvd_reg;
        rd_word[LS_SPEED_LSB +: 3] = evt.resolved_speed_duplex;
      end
      default: ;
    endcase
  end

  // ****************************************************************
  // Management frame engine
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_PRE   = 3'b000,
    ST_HDR   = 3'b001,
    ST_TA    = 3'b010,
    ST_RDATA = 3'b011,
    ST_WDATA = 3'b100
  } pmirq_state_type;

  pmirq_state_type state_reg, state_next;
  logic [5:0]  pre_reg,  pre_next;
  logic [4:0]  cnt_reg,  cnt_next;
  logic [12:0] hdr_reg,  hdr_next;
  logic [15:0] sh_reg,   sh_next;
  logic [4:0]  ra_reg,   ra_next;
  logic        rd_reg,   rd_next;
  logic        out_reg,  out_next;
  logic        oe_reg,   oe_next;
  logic [12:0] hdr_full;

  assign hdr_full = {hdr_reg[11:0], bit_in};
  assign rd_addr  = hdr_full[4:0];
  assign wr_addr  = ra_reg;
  assign wr_data  = {sh_reg[14:0], bit_in};

  // Frame decode; slave output changes just after an MDC rise
  always_comb begin
    state_next = state_reg;
    pre_next   = pre_reg;
    cnt_next   = cnt_reg;
    hdr_next   = hdr_reg;
    sh_next    = sh_reg;
    ra_next    = ra_reg;
    rd_next    = rd_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    wr_stb     = 1'b0;
    flag_clr   = 1'b0;
    if (mdc_rise) begin
      case (state_reg)
        ST_PRE: begin
          if (bit_in) begin
            if (pre_reg != PRE_BITS) pre_next = pre_reg + 6'h01;
          end else begin
            if (pre_reg == PRE_BITS) state_next = ST_HDR;
            pre_next = '0;
            cnt_next = '0;
          end
        end
        ST_HDR: begin
          hdr_next = hdr_full;
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == HDR_LAST) begin
            state_next = ST_PRE;
            cnt_next   = '0;
            // Start bit, own address and a known opcode
            if (hdr_full[12] && hdr_full[9:5] == phy_mgmt_address_reg &&
                (hdr_full[11:10] == OP_READ ||
                 hdr_full[11:10] == OP_WRITE)) begin
              state_next = ST_TA;
              ra_next    = hdr_full[4:0];
              rd_next    = hdr_full[11:10] == OP_READ;
              if (hdr_full[11:10] == OP_READ) begin
                sh_next  = rd_word;
                flag_clr = hdr_full[4:0] == REG_IRQ_FLAGS;
              end
            end
          end
        end
        ST_TA: begin
          cnt_next = cnt_reg + 5'h01;
          if (cnt_reg == TA_LAST) begin
            cnt_next   = '0;
            state_next = rd_reg ? ST_RDATA : ST_WDATA;
            if (rd_reg) begin
              out_next = sh_reg[15];
              sh_next  = {sh_reg[14:0], 1'b0};
            end
          end else if (rd_reg) begin
            oe_next  = 1'b1;
            out_next = 1'b0;
          end
        end
        ST_RDATA: begin
          cnt_next = cnt_reg + 5'h01;
          out_next = sh_reg[15];
          sh_next  = {sh_reg[14:0], 1'b0};
          if (cnt_reg == DATA_LAST) begin
            state_next = ST_PRE;
            oe_next    = 1'b0;
            out_next   = 1'b0;
          end
        end
        ST_WDATA: begin
          cnt_next = cnt_reg + 5'h01;
          sh_next  = wr_data;
          if (cnt_reg == DATA_LAST) begin
            state_next = ST_PRE;
            wr_stb     = 1'b1;
          end
        end
        default: state_next = ST_PRE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_PRE;
      pre_reg   <= '0;
      cnt_reg   <= '0;
      hdr_reg   <= '0;
      sh_reg    <= '0;
      ra_reg    <= '0;
      rd_reg    <= 1'b0;
      out_reg   <= 1'b0;
      oe_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      pre_reg   <= pre_next;
      cnt_reg   <= cnt_next;
      hdr_reg   <= hdr_next;
      sh_reg    <= sh_next;
      ra_reg    <= ra_next;
      rd_reg    <= rd_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  logic             irq_reg;
  pmirq_preset_type preset_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_reg    <= 1'b0;
      preset_reg <= '0;
    end else begin
      irq_reg    <= |(flags_reg & mask_reg);
      preset_reg <= dec_preset;
    end
  end

  assign phy_irq                = irq_reg;
  assign rx_pll_force_reference = pll_reg;
  assign preset                 = preset_reg;
  assign mdio_out               = out_reg;
  assign mdio_oe                = oe_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_mask_write;
    wr_stb && wr_addr == REG_IRQ_MASK;
  endsequence
  sequence s_pll_write;
    wr_stb && wr_addr == REG_CTRL_STATUS;
  endsequence

  property p_irq;
    @(posedge mclk) disable iff (rst)
      ##1 phy_irq == |($past(flags_reg) & $past(mask_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq output does not follow flags and mask");

  property p_link_down;
    @(posedge mclk) disable iff (rst)
      $fell(evt.link_up) |=> flags_reg[4];
  endproperty
  a_link_down: assert property (p_link_down)
    else $error("link down not latched");

  property p_energy;
    @(posedge mclk) disable iff (rst)
      $rose(evt.energy_present) |=> flags_reg[7];
  endproperty
  a_energy: assert property (p_energy)
    else $error("energy event not latched");

  property p_clear;
    @(posedge mclk) disable iff (rst)
      flag_clr && flag_set == '0 |=> flags_reg == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flags not cleared by read");

  property p_mask;
    @(posedge mclk) disable iff (rst)
      s_mask_write |=> mask_reg == $past(wr_data[7:0]);
  endproperty
  a_mask: assert property (p_mask)
    else $error("mask write lost");

  property p_pll;
    @(posedge mclk) disable iff (rst)
      s_pll_write |=> rx_pll_force_reference == $past(wr_data[CS_PLL_BIT]);
  endproperty
  a_pll: assert property (p_pll)
    else $error("pll force bit not applied");

  property p_fixed;
    @(posedge mclk) disable iff (rst)
      rd_addr == REG_CTRL_STATUS |-> rd_word[3:0] == CS_FIXED;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed nibble wrong");

  property p_mode_all;
    @(posedge mclk) disable iff (rst)
      mode_reg == MODE_ALL_ABLE |=> preset.adv_bits == 4'hf
        && preset.ctrl_keep_n == 4'h6;
  endproperty
  a_mode_all: assert property (p_mode_all)
    else $error("all-capable presets wrong");

  property p_mode_10h;
    @(posedge mclk) disable iff (rst)
      mode_reg == MODE_10_HALF |=> preset.ctrl_bits == 4'h0
        && !preset.adv_valid;
  endproperty
  a_mode_10h: assert property (p_mode_10h)
    else $error("10M half presets wrong");

  property p_speed;
    @(posedge mclk) disable iff (rst)
      rd_addr == REG_LINK_STATUS |->
        rd_word[LS_SPEED_LSB +: 3] == evt.resolved_speed_duplex;
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed report wrong");

  property p_flag_hi;
    @(posedge mclk) disable iff (rst)
      rd_addr == REG_IRQ_FLAGS |-> rd_word[15:8] == '0 && !rd_word[0];
  endproperty
  a_flag_hi: assert property (p_flag_hi)
    else $error("reserved flag bits not zero");
endmodule

// ===== pmirq_pkg.sv
package pmirq_pkg;

  // ****************************************************************
  // Register indices on the management interface
  // ****************************************************************
  localparam logic [4:0] REG_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] REG_CTRL_STATUS   = 5'h1b;
  localparam logic [4:0] REG_IRQ_FLAGS     = 5'h1d;
  localparam logic [4:0] REG_IRQ_MASK      = 5'h1e;
  localparam logic [4:0] REG_LINK_STATUS   = 5'h1f;

  // ****************************************************************
  // Management frame layout
  // ****************************************************************
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [5:0] PRE_BITS     = 6'h20;
  localparam logic [4:0] HDR_LAST     = 5'h0c;
  localparam logic [4:0] DATA_LAST    = 5'h0f;
  localparam logic [4:0] TA_LAST      = 5'h01;

  // ****************************************************************
  // Field positions and fixed values
  // ****************************************************************
  localparam int         MODE_LSB      = 5;
  localparam int         CS_PLL_BIT    = 10;
  localparam int         CS_POL_BIT    = 4;
  localparam logic [3:0] CS_FIXED      = 4'hb;
  localparam int         LS_DONE_BIT   = 12;
  localparam int         LS_RSVD_LSB   = 5;
  localparam logic [6:0] LS_RSVD_RESET = 7'h02;
  localparam int         LS_SPEED_LSB  = 2;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [2:0] MODE_RESET    = 3'h7;
  localparam logic [4:0] PHY_MGMT_ADDRESS_RESET   = 5'h01;

  // Operating mode codes
  typedef enum logic [2:0] {
    MODE_10_HALF   = 3'b000,
    MODE_10_FULL   = 3'b001,
    MODE_100_HALF  = 3'b010,
    MODE_100_FULL  = 3'b011,
    MODE_AN_100HD  = 3'b100,
    MODE_REPEATER  = 3'b101,
    MODE_RESERVED  = 3'b110,
    MODE_ALL_ABLE  = 3'b111
  } pmirq_mode_type;

  // Presets for control bits 13,12,10,8 and advertisement bits 8,7,6,5
  typedef struct packed {
    logic [3:0] ctrl_bits;
    logic [3:0] ctrl_keep_n;
    logic [3:0] adv_bits;
    logic       adv_valid;
    logic       crs_on_tx;
    logic       repeater;
  } pmirq_preset_type;

  // Line-side status and events from the PHY core
  typedef struct packed {
    logic       energy_present;
    logic       autoneg_done;
    logic       remote_fault;
    logic       link_up;
    logic       partner_ack;
    logic       parallel_detect_fault;
    logic       page_received;
    logic       ten_meg_polarity_reversed;
    logic [2:0] resolved_speed_duplex;
  } pmirq_evt_type;

endpackage

// ===== pmirq_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs
module pmirq_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule

// ===== pmirq_mode_dec.sv
`timescale 1ns/10ps
// Decodes the operating mode into control and advertisement presets
module pmirq_mode_dec
  import pmirq_pkg::*;
(
  // Mode in
  input  wire logic [2:0]       mode,
  // Presets out
  output pmirq_preset_type      preset
);
  // Code 110 is reserved: nothing is preset, keep everything as is
  always_comb begin
    preset = '0;
    preset.ctrl_keep_n = 4'hf;
    case (pmirq_mode_type'(mode))
      MODE_10_HALF:  preset.ctrl_bits = 4'h0;
      MODE_10_FULL:  preset.ctrl_bits = 4'h1;
      MODE_100_HALF: begin
        preset.ctrl_bits = 4'h8;
        preset.crs_on_tx = 1'b1;
      end
      MODE_100_FULL: preset.ctrl_bits = 4'h9;
      MODE_AN_100HD: begin
        preset.ctrl_bits = 4'hc;
        preset.adv_bits  = 4'h4;
        preset.adv_valid = 1'b1;
        preset.crs_on_tx = 1'b1;
      end
      MODE_REPEATER: begin
        preset.ctrl_bits = 4'hc;
        preset.adv_bits  = 4'h4;
        preset.adv_valid = 1'b1;
        preset.repeater  = 1'b1;
      end
      MODE_ALL_ABLE: begin
        // Speed and duplex bits are don't-care here
        preset.ctrl_bits   = 4'h4;
        preset.ctrl_keep_n = 4'h6;
        preset.adv_bits    = 4'hf;
        preset.adv_valid   = 1'b1;
      end
      default: preset.ctrl_keep_n = 4'h0;
    endcase
  end
endmodule

// ===== pmirq_mgmt_station.sv
`timescale 1ns/10ps
// ****************************************************************
// Management station on the far side of the frame pins
// ****************************************************************
module pmirq_mgmt_station
  import pmirq_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Device side of the data pin
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  // Pins seen by the device
  output logic      mdc,
  output logic      mdio_in
);
  int   half  = 10;
  logic st_d  = 1'b1;
  logic st_oe = 1'b0;

  // Line level: device, then station, else the pull-up
  assign mdio_in = mdio_oe ? mdio_out : (st_oe ? st_d : 1'b1);

  // Clock pin starts low; each frame leaves it high until the next frame
  initial begin
    mdc = 1'b0;
  end

  // One bit: data moves on the low phase, sampled just before the rise
  task automatic bit_cycle(input logic d, input logic oe, output logic s);
    st_d  <= d;
    st_oe <= oe;
    mdc   <= 1'b0;
    repeat (half) @(posedge mclk);
    s = mdio_in;
    mdc <= 1'b1;
    repeat (half) @(posedge mclk);
  endtask

  // Whole frame with full preamble; line released for read turnaround
  task automatic frame(input logic [1:0] op, input logic [4:0] addr,
                       input logic [4:0] idx, input logic [15:0] wdata,
                       output logic [15:0] rdata);
    logic [63:0] frm;
    logic        s;
    frm = {32'hffff_ffff, 2'b01, op, addr, idx, 2'b10, wdata};
    rdata = 16'h0000;
    @(posedge mclk);
    for (int i = 63; i >= 0; i--) begin
      bit_cycle(frm[i], !(op == OP_READ && i < 18), s);
      if (i < 16) begin
        rdata = {rdata[14:0], s};
      end
    end
    // Idle bits let the device release the line before the next frame
    bit_cycle(1'b1, 1'b0, s);
    bit_cycle(1'b1, 1'b0, s);
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top
  import pmirq_pkg::*;
;
  logic             mclk;
  logic             rst;
  logic             mdc;
  logic             mdio_in;
  logic             mdio_out;
  logic             mdio_oe;
  logic [2:0]       strap_mode;
  logic [4:0]       strap_phy_mgmt_address;
  pmirq_evt_type    evt;
  logic             phy_irq;
  logic             rx_pll_force_reference;
  pmirq_preset_type preset;
  int               num_errors = 0;
  int               n_compared = 0;
  logic [15:0]      rd;
  logic [15:0]      pv;
  logic [4:0]       addr;
  logic [2:0]       spds [4] = '{3'b001, 3'b101, 3'b010, 3'b110};
  // Rows: mode code, expected preset, compare mask (110 never written)
  logic [32:0]      rows [7] = '{
    {3'b000, 15'h0780, 15'h7f85}, {3'b001, 15'h0f80, 15'h7f85},
    {3'b010, 15'h4782, 15'h7f87}, {3'b011, 15'h4f80, 15'h7f87},
    {3'b100, 15'h67a6, 15'h7fff}, {3'b101, 15'h67a5, 15'h7fff},
    {3'b111, 15'h237c, 15'h37fd}};

  pmirq_regs i_dut (
    .mclk                   (mclk),
    .rst                    (rst),
    .mdc                    (mdc),
    .mdio_in                (mdio_in),
    .mdio_out               (mdio_out),
    .mdio_oe                (mdio_oe),
    .strap_mode             (strap_mode),
    .strap_phy_mgmt_address (strap_phy_mgmt_address),
    .evt                    (evt),
    .phy_irq                (phy_irq),
    .rx_pll_force_reference (rx_pll_force_reference),
    .preset                 (preset)
  );

  pmirq_mgmt_station i_mgmt (
    .mclk     (mclk),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .mdc      (mdc),
    .mdio_in  (mdio_in)
  );

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] idx, input logic [15:0] data);
    i_mgmt.frame(OP_WRITE, addr, idx, data, rd);
  endtask

  task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
    i_mgmt.frame(OP_READ, addr, idx, 16'h0000, rd);
    check_val(rd, exp);
  endtask

  task automatic conclude();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog, roughly twice the expected run
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    strap_mode = 3'b100;
    strap_phy_mgmt_address = 5'h03;
    evt = '0;
    evt.link_up = 1'b1;
    addr = 5'h03;
    repeat (12) @(posedge mclk);
    check_val(16'({phy_irq, rx_pll_force_reference, mdio_oe}), 16'h0000);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    check_val(16'(preset), 16'h67a6);
    rd_chk(REG_SPECIAL_MODES, 16'h0083);
    rd_chk(REG_IRQ_FLAGS, 16'h0000);
    rd_chk(REG_IRQ_MASK, 16'h0000);
    rd_chk(REG_CTRL_STATUS, 16'h000b);
    rd_chk(REG_LINK_STATUS, 16'h0040);
    rd_chk(5'h03, 16'h0000);
    // Mode table through the special modes register
    for (int i = 0; i < 7; i++) begin
      wr(REG_SPECIAL_MODES, {8'h00, rows[i][32:30], addr});
      pv = 16'(preset) & 16'(rows[i][14:0]);
      check_val(pv, 16'(rows[i][29:15]));
      check_val(pv, 16'(rows[i][29:15]));
    end
    // New address: the old one is no longer answered
    wr(REG_SPECIAL_MODES, {8'h00, 3'b111, 5'h05});
    rd_chk(REG_SPECIAL_MODES, 16'hffff);
    addr = 5'h05;
    rd_chk(REG_SPECIAL_MODES, 16'h00e5);
    // PLL force, polarity, fixed low nibble
    for (int k = 0; k < 2; k++) begin
      evt.ten_meg_polarity_reversed <= k[0];
      wr(REG_CTRL_STATUS, k[0] ? 16'h040f : 16'h001f);
      check_val(16'(rx_pll_force_reference), 16'(k[0]));
      rd_chk(REG_CTRL_STATUS, k[0] ? 16'h041b : 16'h000b);
    end
    // All sources fire while masked
    evt[10:4] <= 7'b1110111;
    repeat (4) @(posedge mclk);
    check_val(16'(phy_irq), 16'h0000);
    rd_chk(REG_IRQ_FLAGS, 16'h00fe);
    rd_chk(REG_IRQ_FLAGS, 16'h0000);
    wr(REG_IRQ_MASK, 16'hff10);
    rd_chk(REG_IRQ_MASK, 16'h0010);
    evt[10:4] <= 7'b0001000;
    repeat (4) @(posedge mclk);
    evt[10] <= 1'b1;
    repeat (4) @(posedge mclk);
    check_val(16'(phy_irq), 16'h0000);
    evt[7] <= 1'b0;
    repeat (4) @(posedge mclk);
    check_val(16'(phy_irq), 16'h0001);
    rd_chk(REG_IRQ_FLAGS, 16'h0090);
    check_val(16'(phy_irq), 16'h0000);
    // Resolved link and completion
    evt[9] <= 1'b1;
    wr(REG_LINK_STATUS, 16'h0040);
    for (int k = 0; k < 4; k++) begin
      evt[2:0] <= spds[k];
      rd_chk(REG_LINK_STATUS, 16'h1040 | {11'h0, spds[k], 2'b00});
    end
    // Autoneg off hides completion; slow station on this read
    wr(REG_SPECIAL_MODES, {8'h00, 3'b000, addr});
    i_mgmt.half = 16;
    rd_chk(REG_LINK_STATUS, 16'h0058);
    conclude();
  end
endmodule
